/* design/tbs_consts.svh */
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Included by the sequencer design and by the bench.
// Notes:   Offsets are byte addresses of 32-bit aligned words.
`ifndef TBS_CONSTS_SVH
`define TBS_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define TBS_OFS_CTRL       8'h00
`define TBS_OFS_CFG_STAT   8'h04
`define TBS_OFS_IRQ_STAT   8'h08
`define TBS_OFS_IRQ_MASK   8'h0C
`define TBS_OFS_SEQ_CMD    8'h10
`define TBS_OFS_SEQ_WDATA  8'h14
`define TBS_OFS_SEQ_RDATA  8'h18
`define TBS_OFS_SEQ_STAT   8'h1C
`define TBS_OFS_PRINT_SEL  8'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define TBS_CTRL_LATCH_EN  0
`define TBS_CTRL_EDIT_CLR  1
`define TBS_IRQ_KEY        0
`define TBS_IRQ_LINE       1
`define TBS_IRQ_TIMER      2
`define TBS_IRQ_MOTOR      3
`define TBS_IRQ_SEQ_DONE   4
`define TBS_IRQ_BITS       5
`define TBS_STAT_BUSY      0
`define TBS_STAT_EDIT      1

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define TBS_RST_IRQ_MASK   5'h00
`define TBS_RST_PRINT_SEL  16'h0000
`define TBS_EDIT_OPCODE    8'h45

// ****************************************************************
// Timing
// ****************************************************************
`define TBS_CLK_MHZ        40
`define TBS_STROBE_NS      250
`define TBS_STROBE_CYC     ((`TBS_STROBE_NS * `TBS_CLK_MHZ + 999) / 1000)

`endif

/* design/tbs_pkg.sv */
// Purpose: Types shared by the sequencer design and the bench.
// Assumes: Constants live in tbs_consts.svh.
// Notes:   Operation codes match bits 17:16 of the command register.
package tbs_pkg;

    typedef enum logic [1:0]
    {
        TBS_OP_KB_READ,
        TBS_OP_MEM_WRITE,
        TBS_OP_MEM_READ,
        TBS_OP_PRINT
    } tbs_op_e;

    typedef enum
    {
        TBS_SQ_IDLE,
        TBS_SQ_SETUP,
        TBS_SQ_STROBE,
        TBS_SQ_HOLD
    } tbs_seq_e;

endpackage

/* design/tbs_sequencer.sv */
// Purpose: Status characters, interrupt mask latches and system-bus
//          transfer sequencing of the terminal processor module.
// Assumes: One 40 MHz clock; AHB-Lite slave with one read wait state.
// Notes:   All pin inputs pass a two-flop synchroniser first.
`timescale 1ns/1ps
`include "tbs_consts.svh"

// Notes on behaviour
// - Char six bit1 is paper adequate.
// - Char six bit2 is double spacing selected.
// - Char six bit3 is printing disabled.
// - Char six bit0 always reads reset position.
// - Char seven bit4 is cover open.
// - Char seven bit5 is second step absent.
// - Char seven bits 7 and 6 read one.
// - Char eight bit1 is fan off.
// - Char eight bit3 is motor decelerating.
// - Char eight bits 0 and 2 fixed.
// - At power-on only timer, motor and sequence-done interrupts pass.
// - Software sets latches enabling keyboard, line interrupts.
// - Read keyboard character, decode edit opcode.
// - Memory write: address, data, then write strobe.
// - Memory read: address, then read strobe.
// - Print: select code, data, then io write strobe.
module tbs_sequencer
(
    input  wire logic                 i_clk,
    input  wire logic                 i_resetn,
    input  wire logic                 i_hsel,
    input  wire logic [7:0]           i_haddr,
    input  wire logic [1:0]           i_htrans,
    input  wire logic                 i_hwrite,
    input  wire logic [2:0]           i_hsize,
    input  wire logic [31:0]          i_hwdata,
    input  wire logic                 i_hready,
    output logic                      o_hreadyout,
    output logic                      o_hresp,
    output logic      [31:0]          o_hrdata,
    input  wire logic                 i_paper_ok,
    input  wire logic                 i_double_space,
    input  wire logic                 i_print_disabled,
    input  wire logic                 i_cover_open,
    input  wire logic                 i_second_step_absent,
    input  wire logic                 i_fan_off,
    input  wire logic                 i_motor_slowing,
    input  wire logic                 i_key_press_irq,
    input  wire logic                 i_line_irq,
    input  wire logic                 i_timer_irq,
    input  wire logic                 i_motor_clk_irq,
    input  wire logic [7:0]           i_keyboard_char_bus,
    input  wire logic [7:0]           i_sys_data,
    output logic      [7:0]           o_sys_data,
    output logic                      o_sys_data_oe_n,
    output logic      [15:0]          o_sys_addr,
    output logic                      o_mem_write_strobe,
    output logic                      o_mem_read_strobe,
    output logic                      o_io_write_strobe,
    output logic                      o_edit_mode,
    output logic                      o_irq
);
    import tbs_pkg::*;

    localparam int NSYNC = 27;
    localparam logic [3:0] STROBE_CYC = 4'(`TBS_STROBE_CYC);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;

    assign pin_raw = {i_sys_data, i_keyboard_char_bus, i_motor_clk_irq,
                      i_timer_irq, i_line_irq, i_key_press_irq,
                      i_motor_slowing, i_fan_off, i_second_step_absent,
                      i_cover_open, i_print_disabled, i_double_space,
                      i_paper_ok};

    genvar g;
    generate
        for (g = 0; g < NSYNC; g++)
        begin : g_sync
            always_ff @(posedge i_clk or negedge i_resetn)
            begin
                if (!i_resetn)
                begin
                    sync_a[g] <= 1'b0;
                    sync_b[g] <= 1'b0;
                end
                else
                begin
                    sync_a[g] <= pin_raw[g];
                    sync_b[g] <= sync_a[g];
                end
            end
        end
    endgenerate

    logic       paper_ok;
    logic       double_space;
    logic       print_disabled;
    logic       cover_open;
    logic       second_step_absent;
    logic       fan_off;
    logic       motor_slowing;
    logic [3:0] irq_lvl;
    logic [7:0] kb_char;
    logic [7:0] sys_data_in;

    assign paper_ok           = sync_b[0];
    assign double_space       = sync_b[1];
    assign print_disabled     = sync_b[2];
    assign cover_open         = sync_b[3];
    assign second_step_absent = sync_b[4];
    assign fan_off            = sync_b[5];
    assign motor_slowing      = sync_b[6];
    assign irq_lvl            = sync_b[10:7];
    assign kb_char            = sync_b[18:11];
    assign sys_data_in        = sync_b[26:19];

    // ************************************************************
    // Configuration status characters
    // ************************************************************
    logic [7:0] char_six;
    logic [7:0] char_seven;
    logic [7:0] char_eight;

    assign char_six   = {4'h0,
                         print_disabled,
                         double_space,
                         paper_ok,
                         1'b0};
    assign char_seven = {2'b11,
                         second_step_absent,
                         cover_open,
                         4'h0};
    assign char_eight = {4'h0,
                         motor_slowing,
                         1'b0,
                         fan_off,
                         1'b0};

    // ************************************************************
    // AHB-Lite slave front end
    // ************************************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    logic       take;
    logic       wr_pend;
    logic       rd_pend;
    logic [7:0] ph_addr;
    logic       wr_en;

    assign take        = i_hsel && i_htrans[1] && i_hready;
    assign o_hreadyout = !rd_pend;
    assign o_hresp     = 1'b0;
    assign wr_en       = wr_pend;

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            ph_addr <= 8'h00;
        end
        else
        begin
            wr_pend <= take && i_hwrite;
            rd_pend <= take && !i_hwrite;
            if (take)
                ph_addr <= i_haddr;
        end
    end

    // ************************************************************
    // Interrupt mask latches, sticky status and mask
    // ************************************************************
    logic                      latch_en;
    logic [3:0]                irq_prev;
    logic [3:0]                irq_edge;
    logic [3:0]                irq_pass;
    logic [`TBS_IRQ_BITS-1:0]  irq_set;
    logic [`TBS_IRQ_BITS-1:0]  irq_stat;
    logic [`TBS_IRQ_BITS-1:0]  irq_mask;
    logic [`TBS_IRQ_BITS-1:0]  irq_clr;
    logic                      seq_done;

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            latch_en <= 1'b0;
        else if (wr_en && hit(ph_addr, `TBS_OFS_CTRL))
            latch_en <= i_hwdata[`TBS_CTRL_LATCH_EN];
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            irq_prev <= 4'h0;
        else
            irq_prev <= irq_lvl;
    end

    // One event per key depression is relied on from the keyboard.
    assign irq_edge = irq_lvl & ~irq_prev;
    assign irq_pass = {irq_edge[3:2],
                       irq_edge[1:0] & {2{latch_en}}};
    assign irq_set  = {seq_done, irq_pass};
    assign irq_clr  = (wr_en && hit(ph_addr, `TBS_OFS_IRQ_STAT)) ?
                      i_hwdata[`TBS_IRQ_BITS-1:0] : '0;

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            irq_stat <= '0;
        else
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            irq_mask <= `TBS_RST_IRQ_MASK;
        else if (wr_en && hit(ph_addr, `TBS_OFS_IRQ_MASK))
            irq_mask <= i_hwdata[`TBS_IRQ_BITS-1:0];
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_irq <= 1'b0;
        else
            o_irq <= |(irq_stat & irq_mask);
    end

    // ************************************************************
    // Transfer command registers
    // ************************************************************
    tbs_seq_e    seq_st;
    tbs_op_e     cur_op;
    logic [15:0] cmd_addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [15:0] print_sel;
    logic [3:0]  strobe_cnt;
    logic        start;

    assign start = wr_en && hit(ph_addr, `TBS_OFS_SEQ_CMD) &&
                   (seq_st == TBS_SQ_IDLE);

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cur_op   <= TBS_OP_KB_READ;
            cmd_addr <= 16'h0000;
        end
        else if (start)
        begin
            cur_op   <= tbs_op_e'(i_hwdata[17:16]);
            cmd_addr <= i_hwdata[15:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            wdata <= 8'h00;
        else if (wr_en && hit(ph_addr, `TBS_OFS_SEQ_WDATA))
            wdata <= i_hwdata[7:0];
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            print_sel <= `TBS_RST_PRINT_SEL;
        else if (wr_en && hit(ph_addr, `TBS_OFS_PRINT_SEL))
            print_sel <= i_hwdata[15:0];
    end

    // ************************************************************
    // Bus transfer sequencer
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            seq_st     <= TBS_SQ_IDLE;
            strobe_cnt <= 4'h0;
            seq_done   <= 1'b0;
        end
        else
        begin
            seq_done <= 1'b0;
            case (seq_st)
                TBS_SQ_IDLE:
                    if (start)
                        seq_st <= TBS_SQ_SETUP;
                TBS_SQ_SETUP:
                begin
                    strobe_cnt <= STROBE_CYC;
                    seq_st     <= TBS_SQ_STROBE;
                end
                TBS_SQ_STROBE:
                begin
                    strobe_cnt <= strobe_cnt - 4'h1;
                    if (strobe_cnt == 4'h1)
                        seq_st <= TBS_SQ_HOLD;
                end
                TBS_SQ_HOLD:
                begin
                    seq_done <= 1'b1;
                    seq_st   <= TBS_SQ_IDLE;
                end
                default:
                    seq_st <= TBS_SQ_IDLE;
            endcase
        end
    end

    // Address and write data stand from setup through hold.
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_sys_addr      <= 16'h0000;
            o_sys_data      <= 8'h00;
            o_sys_data_oe_n <= 1'b1;
        end
        else if (seq_st == TBS_SQ_IDLE)
        begin
            o_sys_data_oe_n <= 1'b1;
            if (start)
            begin
                if (tbs_op_e'(i_hwdata[17:16]) == TBS_OP_PRINT)
                    o_sys_addr <= print_sel;
                else
                    o_sys_addr <= i_hwdata[15:0];
                o_sys_data      <= wdata;
                o_sys_data_oe_n <=
                    !(tbs_op_e'(i_hwdata[17:16]) == TBS_OP_MEM_WRITE ||
                      tbs_op_e'(i_hwdata[17:16]) == TBS_OP_PRINT);
            end
        end
        else if (seq_st == TBS_SQ_HOLD)
            o_sys_data_oe_n <= 1'b1;
    end

    logic strobe_on;
    assign strobe_on = (seq_st == TBS_SQ_SETUP) ||
                       (seq_st == TBS_SQ_STROBE && strobe_cnt != 4'h1);

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_mem_write_strobe <= 1'b0;
            o_mem_read_strobe  <= 1'b0;
            o_io_write_strobe  <= 1'b0;
        end
        else
        begin
            o_mem_write_strobe <= strobe_on &&
                                  cur_op == TBS_OP_MEM_WRITE;
            o_mem_read_strobe  <= strobe_on &&
                                  cur_op == TBS_OP_MEM_READ;
            o_io_write_strobe  <= strobe_on &&
                                  cur_op == TBS_OP_PRINT;
        end
    end

    // Read data is taken as the strobe ends, when the bus has settled.
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            rdata <= 8'h00;
        else if (seq_st == TBS_SQ_STROBE && strobe_cnt == 4'h1)
        begin
            if (cur_op == TBS_OP_KB_READ)
                rdata <= kb_char;
            else if (cur_op == TBS_OP_MEM_READ)
                rdata <= sys_data_in;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_edit_mode <= 1'b0;
        else if (seq_st == TBS_SQ_STROBE && strobe_cnt == 4'h1 &&
                 cur_op == TBS_OP_KB_READ &&
                 kb_char == `TBS_EDIT_OPCODE)
            o_edit_mode <= 1'b1;
        else if (wr_en && hit(ph_addr, `TBS_OFS_CTRL) &&
                 i_hwdata[`TBS_CTRL_EDIT_CLR])
            o_edit_mode <= 1'b0;
    end

    // ************************************************************
    // Register read-back
    // ************************************************************
    logic [31:0] rd_val;

    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (hit(ph_addr, `TBS_OFS_CTRL))
            rd_val[`TBS_CTRL_LATCH_EN] = latch_en;
        else if (hit(ph_addr, `TBS_OFS_CFG_STAT))
            rd_val = {8'h00, char_eight, char_seven, char_six};
        else if (hit(ph_addr, `TBS_OFS_IRQ_STAT))
            rd_val[`TBS_IRQ_BITS-1:0] = irq_stat;
        else if (hit(ph_addr, `TBS_OFS_IRQ_MASK))
            rd_val[`TBS_IRQ_BITS-1:0] = irq_mask;
        else if (hit(ph_addr, `TBS_OFS_SEQ_CMD))
            rd_val = {14'h0000, cur_op, cmd_addr};
        else if (hit(ph_addr, `TBS_OFS_SEQ_WDATA))
            rd_val[7:0] = wdata;
        else if (hit(ph_addr, `TBS_OFS_SEQ_RDATA))
            rd_val[7:0] = rdata;
        else if (hit(ph_addr, `TBS_OFS_SEQ_STAT))
            rd_val[1:0] = {o_edit_mode, seq_st != TBS_SQ_IDLE};
        else if (hit(ph_addr, `TBS_OFS_PRINT_SEL))
            rd_val[15:0] = print_sel;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_hrdata <= 32'h0000_0000;
        else if (rd_pend)
            o_hrdata <= rd_val;
    end

endmodule

/* tb/tbs_sequencer_sva.sv */
// Purpose: Concurrent checks on bus and strobe pins.
// Assumes: One clock domain.
// Notes:   Strobe width is counted.
`timescale 1ns/1ps
`include "tbs_consts.svh"
module tbs_sequencer_sva
(
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic        i_hsel,
    input wire logic [7:0]  i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic        i_hready,
    input wire logic        o_hreadyout,
    input wire logic [31:0] o_hrdata,
    input wire logic [7:0]  o_sys_data,
    input wire logic        o_sys_data_oe_n,
    input wire logic [15:0] o_sys_addr,
    input wire logic        o_mem_write_strobe,
    input wire logic        o_mem_read_strobe,
    input wire logic        o_io_write_strobe
);
    logic       any_stb;
    logic [4:0] stb_len;
    logic       rd_ph;
    logic       rd_cfg;

    assign any_stb = o_mem_write_strobe | o_mem_read_strobe
                   | o_io_write_strobe;

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            stb_len <= 5'h00;
        else
            stb_len <= any_stb ? stb_len + 5'h01 : 5'h00;
    end

    // Tracks read data phases of the status word.
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rd_ph  <= 1'b0;
            rd_cfg <= 1'b0;
        end
        else if (o_hreadyout)
        begin
            rd_ph  <= i_hsel & i_htrans[1] & i_hready & !i_hwrite;
            rd_cfg <= i_haddr == `TBS_OFS_CFG_STAT;
        end
    end

    default clocking dcb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    stb_len_a:
        assert property ($fell(any_stb) |-> stb_len == 5'h0A)
        else $error("Bad strobe width.");
    stb_one_a:
        assert property ($onehot0({o_mem_write_strobe, o_mem_read_strobe,
                                   o_io_write_strobe}))
        else $error("Two strobes high.");
    addr_hold_a:
        assert property (any_stb |-> $stable(o_sys_addr))
        else $error("Address moved.");
    wr_drive_a:
        assert property (o_mem_write_strobe |->
                         !o_sys_data_oe_n && $stable(o_sys_data))
        else $error("Write data moved.");
    wr_setup_a:
        assert property ($rose(o_mem_write_strobe) |->
                         $past(o_sys_data_oe_n) == 1'b0)
        else $error("Write data late.");
    rd_float_a:
        assert property (o_mem_read_strobe |-> o_sys_data_oe_n)
        else $error("Bus driven in read.");
    io_drive_a:
        assert property (o_io_write_strobe |->
                         !o_sys_data_oe_n && $stable(o_sys_data))
        else $error("Print data moved.");
    cfg_fixed_a:
        assert property (rd_ph && o_hreadyout && rd_cfg |->
                         o_hrdata[15:14] == 2'h3 && o_hrdata[0] == 1'b0
                         && o_hrdata[16] == 1'b0 && o_hrdata[18] == 1'b0)
        else $error("Fixed status bits wrong.");

    cover property ($rose(o_mem_write_strobe));
    cover property ($rose(o_mem_read_strobe));
    cover property ($rose(o_io_write_strobe));
endmodule

bind tbs_sequencer tbs_sequencer_sva i_sva
(
    .i_clk, .i_resetn, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hready, .o_hreadyout, .o_hrdata, .o_sys_data, .o_sys_data_oe_n,
    .o_sys_addr, .o_mem_write_strobe, .o_mem_read_strobe,
    .o_io_write_strobe
);

/* tb/tbs_far_side.sv */
// Purpose: Keyboard, message store and print controller.
// Assumes: Strobes are active high.
// Notes:   A released bus shows the inverse of the last read byte.
`timescale 1ns/1ps
module tbs_far_side
#(
    parameter logic [15:0] PRINT_ADDR = 16'h0300
)
(
    input  wire logic        i_clk,
    input  wire logic        i_key_hit,
    input  wire logic [7:0]  i_key_code,
    input  wire logic [7:0]  i_sys_data,
    input  wire logic        i_sys_data_oe_n,
    input  wire logic [15:0] i_sys_addr,
    input  wire logic        i_mem_write_strobe,
    input  wire logic        i_mem_read_strobe,
    input  wire logic        i_io_write_strobe,
    output logic             o_key_press_irq,
    output logic      [7:0]  o_keyboard_char_bus,
    output logic      [7:0]  o_sys_data,
    output logic      [7:0]  o_head_pattern
);
    logic [7:0] mem [0:255];
    logic [7:0] last = 8'hA5;
    logic       io_q = 1'b0;

    always_ff @(posedge i_clk)
    begin
        o_key_press_irq <= i_key_hit;
        o_keyboard_char_bus <= i_key_code;
        io_q <= i_io_write_strobe;
        if (i_mem_write_strobe && !i_sys_data_oe_n)
            mem[i_sys_addr[7:0]] <= i_sys_data;
        if (i_mem_read_strobe)
        begin
            o_sys_data <= mem[i_sys_addr[7:0]];
            last <= mem[i_sys_addr[7:0]];
        end
        else
            o_sys_data <= ~last;
        if (i_io_write_strobe && !io_q && i_sys_addr == PRINT_ADDR)
            o_head_pattern <= i_sys_data;
    end
endmodule

/* tb/test_tbs_sequencer.sv */
// Purpose: Self-checking bench for the terminal bus sequencer.
// Assumes: Far side modelled in tbs_far_side.
// Notes:   Ready and read data are taken at the rising edge.
`timescale 1ns/1ps
`include "tbs_consts.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module test_tbs_sequencer;
    import tbs_pkg::*;
    localparam logic [23:0] AD = 24'h00FF12;
    localparam logic [23:0] DT = 24'h00A55A;
    logic        clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [6:0]  sens = 7'h00;
    logic [3:0]  irqv = 4'h0;
    logic [7:0]  key_code = 8'h00;
    logic        hready, hresp, key_irq, oe_n, wstb, rstb, iostb, edit, irq;
    logic [31:0] hrdata, rdv;
    logic [7:0]  kb_bus, sd_in, sd_out, head;
    logic [15:0] saddr;
    int          failures = 0, checked = 0, cycles = 0;

    tbs_sequencer i_dut
    (
        .i_clk(clk), .i_resetn(resetn), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
        .o_hresp(hresp), .o_hrdata(hrdata), .i_paper_ok(sens[0]),
        .i_double_space(sens[1]), .i_print_disabled(sens[2]),
        .i_cover_open(sens[3]), .i_second_step_absent(sens[4]),
        .i_fan_off(sens[5]), .i_motor_slowing(sens[6]),
        .i_key_press_irq(key_irq), .i_line_irq(irqv[1]),
        .i_timer_irq(irqv[2]), .i_motor_clk_irq(irqv[3]),
        .i_keyboard_char_bus(kb_bus), .i_sys_data(sd_in),
        .o_sys_data(sd_out), .o_sys_data_oe_n(oe_n), .o_sys_addr(saddr),
        .o_mem_write_strobe(wstb), .o_mem_read_strobe(rstb),
        .o_io_write_strobe(iostb), .o_edit_mode(edit), .o_irq(irq)
    );

    tbs_far_side i_far
    (
        .i_clk(clk), .i_key_hit(irqv[0]), .i_key_code(key_code),
        .i_sys_data(sd_out), .i_sys_data_oe_n(oe_n), .i_sys_addr(saddr),
        .i_mem_write_strobe(wstb), .i_mem_read_strobe(rstb),
        .i_io_write_strobe(iostb), .o_key_press_irq(key_irq),
        .o_keyboard_char_bus(kb_bus), .o_sys_data(sd_in),
        .o_head_pattern(head)
    );

    always #12.5 clk = ~clk;

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            summarize();
        end
    end

    task summarize;
        if (failures == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Ends on the rising edge at which ready is sampled high.
    task wait_rdy;
        @(posedge clk);
        while (hready !== 1'b1)
            @(posedge clk);
        rdv = hrdata;
    endtask

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a);
        ahb(1'b0, a, 32'h0);
    endtask

    task seq(input tbs_op_e op, input logic [15:0] a);
        wr(`TBS_OFS_SEQ_CMD, {14'h0, op, a});
        cyc(2);
        rd(`TBS_OFS_SEQ_STAT);
        while (rdv[0] !== 1'b0)
            rd(`TBS_OFS_SEQ_STAT);
    endtask

    task pulse(input logic [3:0] v);
        irqv <= v;
        cyc(3);
        irqv <= 4'h0;
        cyc(5);
    endtask

    task t_reset;
        rd(`TBS_OFS_IRQ_MASK);
        `CHK("mask", 32'h0, rdv)
        rd(`TBS_OFS_PRINT_SEL);
        `CHK("print_sel", 32'h0, rdv)
        wr(8'h24, 32'hFFFFFFFF);
        rd(8'h24);
        `CHK("unmapped", 32'h0, rdv)
        `CHK("hresp", 1'b0, hresp)
        `CHK("oe_n", 1'b1, oe_n)
    endtask

    task t_status;
        logic [31:0] e;
        for (int k = 0; k < 128; k++)
        begin
            sens <= k[6:0];
            cyc(4);
            rd(`TBS_OFS_CFG_STAT);
            e = {12'h0, k[6], 1'b0, k[5], 1'b0, 2'h3, k[4:3], 8'h0,
                 k[2:0], 1'b0};
            `CHK("cfg", e, rdv)
        end
    endtask

    task t_irq;
        wr(`TBS_OFS_IRQ_MASK, 32'h1F);
        pulse(4'hF);
        rd(`TBS_OFS_IRQ_STAT);
        `CHK("stat_poweron", 32'h0C, rdv)
        `CHK("irq_on", 1'b1, irq)
        wr(`TBS_OFS_IRQ_STAT, 32'h0C);
        cyc(2);
        `CHK("irq_cleared", 1'b0, irq)
        wr(`TBS_OFS_CTRL, 32'h1);
        pulse(4'h3);
        rd(`TBS_OFS_IRQ_STAT);
        `CHK("stat_enabled", 32'h03, rdv)
        wr(`TBS_OFS_IRQ_MASK, 32'h1C);
        cyc(2);
        `CHK("irq_masked", 1'b0, irq)
        wr(`TBS_OFS_IRQ_STAT, 32'h03);
        resetn <= 1'b0;
        cyc(2);
        resetn <= 1'b1;
        cyc(2);
        rd(`TBS_OFS_IRQ_MASK);
        `CHK("mask_reset", 32'h0, rdv)
        wr(`TBS_OFS_IRQ_MASK, 32'h1F);
        pulse(4'h1);
        rd(`TBS_OFS_IRQ_STAT);
        `CHK("stat_relatched", 32'h0, rdv)
    endtask

    task t_kb;
        for (int i = 0; i < 2; i++)
        begin
            wr(`TBS_OFS_CTRL, 32'h3);
            key_code <= i ? 8'h41 : `TBS_EDIT_OPCODE;
            pulse(4'h1);
            seq(TBS_OP_KB_READ, 16'h0000);
            rd(`TBS_OFS_SEQ_RDATA);
            `CHK("kb_char", {24'h0, key_code}, rdv)
            `CHK("edit", i == 0, edit)
        end
    endtask

    task t_mem;
        for (int i = 0; i < 3; i++)
        begin
            wr(`TBS_OFS_SEQ_WDATA, {24'h0, DT[8*i+:8]});
            seq(TBS_OP_MEM_WRITE, {8'h00, AD[8*i+:8]});
            `CHK("stored", DT[8*i+:8], i_far.mem[AD[8*i+:8]])
        end
        for (int i = 2; i >= 0; i--)
        begin
            seq(TBS_OP_MEM_READ, {8'h00, AD[8*i+:8]});
            rd(`TBS_OFS_SEQ_RDATA);
            `CHK("fetched", {24'h0, DT[8*i+:8]}, rdv)
        end
        wr(`TBS_OFS_SEQ_WDATA, 32'h77);
        wr(`TBS_OFS_SEQ_CMD, 32'h10020);
        seq(TBS_OP_MEM_WRITE, 16'h0012);
        `CHK("busy_ignored", 8'h5A, i_far.mem[8'h12])
        `CHK("first_kept", 8'h77, i_far.mem[8'h20])
    endtask

    task t_print;
        wr(`TBS_OFS_PRINT_SEL, 32'h0300);
        for (int i = 0; i < 2; i++)
        begin
            wr(`TBS_OFS_SEQ_WDATA, i ? 32'h7E : 32'h41);
            seq(TBS_OP_PRINT, 16'h0000);
            `CHK("printed", i ? 8'h7E : 8'h41, head)
        end
    endtask

    initial
    begin
        cyc(20);
        resetn <= 1'b1;
        cyc(2);
        t_reset();
        t_status();
        t_irq();
        t_kb();
        t_mem();
        t_print();
        summarize();
    end
endmodule
